// ### logic/mii_phy_port_strap_latch.sv
// phy side of the mii: link clocks, receive path, transmit capture, straps
`timescale 1ns/1ps

module mii_phy_port_strap_latch
    import mii_strap_pkg::*;
#(
    parameter int HALF_CYC = LINK_HALF_CYC
) (
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    // user receive stream toward the mac
    input  wire logic                           rx_in_valid,
    output logic                                rx_in_ready,
    input  wire mii_strap_pkg::nibble_word_t    rx_in_data,
    input  wire logic                           rx_carrier,
    // shared receive pins, three signals each, then rx_dv and rx_er as plain outputs
    input  wire logic [mii_strap_pkg::NIBBLE_W-1:0] rxd_in,
    output logic      [mii_strap_pkg::NIBBLE_W-1:0] rxd_out,
    output logic                                rxd_oe,
    input  wire logic                           rx_clk_in,
    output logic                                rx_clk_out,
    output logic                                rx_clk_oe,
    input  wire logic                           crs_in,
    output logic                                crs_out,
    output logic                                crs_oe,
    output logic                                rx_dv,
    output logic                                rx_er,
    // transmit pins
    output logic                                tx_clk,
    input  wire logic                           tx_en,
    input  wire logic [mii_strap_pkg::NIBBLE_W-1:0] txd,
    input  wire logic                           tx_er,
    // user transmit side
    output logic                                tx_valid,
    output mii_strap_pkg::nibble_word_t         tx_data,
    // latched straps
    output mii_strap_pkg::strap_set_t           straps,
    output logic                                straps_valid
);

    import mii_strap_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    strap_pins_t strap_meta;
    strap_pins_t strap_sync;
    tx_pins_t    tx_meta;
    tx_pins_t    tx_sync;

    // pins are asynchronous to clk_sys; meta stage feeds only the sync stage
    always_ff @(posedge clk_sys) begin
        strap_meta <= '{rxd: rxd_in, rx_clk: rx_clk_in, crs: crs_in};
        strap_sync <= strap_meta;
        tx_meta    <= '{en: tx_en, er: tx_er, txd: txd};
        tx_sync    <= tx_meta;
    end

    // ****************************************
    // reset release and strap capture
    // ****************************************
    logic srst_q;
    logic running;
    wire  release_evt = srst_q && !srst;

    // straps are caught by a clocked edge after release, not by the reset
    always_ff @(posedge clk_sys) begin
        srst_q <= srst;
    end

    // address is built once from the pin map, upper bits tied off
    wire [ADDR_W-1:0] next_address = {
        ADDR_HI_FIXED,
        strap_sync.rxd[RXD_ADDR2_POS],
        strap_sync.rxd[RXD_ADDR1_POS],
        strap_sync.rxd[RXD_ADDR0_POS]
    };
    wire strap_set_t next_straps = '{
        station_address: next_address,
        duplex:          strap_sync.rxd[RXD_DUPLEX_POS],
        mode_select:     {strap_sync.crs, strap_sync.rx_clk}
    };

    // only a release edge writes the straps, so they hold until next reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            straps       <= '0;
            straps_valid <= 1'b0;
            running      <= 1'b0;
        end else if (release_evt) begin
            straps       <= next_straps;
            straps_valid <= 1'b1;
            running      <= 1'b1;
        end
    end

    // ****************************************
    // pin direction
    // ****************************************
    // enables rise only once the straps are safely captured
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxd_oe    <= 1'b0;
            rx_clk_oe <= 1'b0;
            crs_oe    <= 1'b0;
        end else begin
            rxd_oe    <= running;
            rx_clk_oe <= running;
            crs_oe    <= running;
        end
    end

    // ****************************************
    // link clock divider
    // ****************************************
    logic [DIV_W-1:0] div_cnt;
    logic             link_clk;
    wire              div_wrap = (div_cnt == DIV_W'(HALF_CYC - 1));
    // edge enables toward the mac's view of the clock
    wire              fall_evt = running && div_wrap && link_clk;
    wire              rise_evt = running && div_wrap && !link_clk;

    // one free divider serves both link clocks, so they stay in phase
    always_ff @(posedge clk_sys) begin
        if (srst || !running) begin
            div_cnt  <= '0;
            link_clk <= 1'b0;
        end else if (div_wrap) begin
            div_cnt  <= '0;
            link_clk <= !link_clk;
        end else begin
            div_cnt  <= DIV_W'(div_cnt + 1'b1);
        end
    end

    // both clock pins come from their own flops of the same divider
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_clk_out <= 1'b0;
            tx_clk     <= 1'b0;
        end else begin
            rx_clk_out <= (div_wrap && running) ? !link_clk : link_clk;
            tx_clk     <= (div_wrap && running) ? !link_clk : link_clk;
        end
    end

    // ****************************************
    // receive path
    // ****************************************
    logic         fifo_valid;
    nibble_word_t fifo_data;
    // one nibble leaves per receive clock, at the falling edge
    wire          fifo_take = fall_evt;

    nibble_fifo #(
        .WIDTH ($bits(nibble_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_data   (rx_in_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data)
    );

    // change on the falling edge so the mac sees stable data at rising
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxd_out   <= '0;
            rx_dv     <= 1'b0;
            rx_er     <= 1'b0;
        end else if (fall_evt) begin
            rxd_out   <= fifo_valid ? fifo_data.nibble : '0;
            rx_dv     <= fifo_valid;
            rx_er     <= fifo_valid && fifo_data.err;
        end
    end

    // carrier follows the same edge as data valid
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            crs_out <= 1'b0;
        end else if (fall_evt) begin
            crs_out <= rx_carrier || fifo_valid;
        end
    end

    // ****************************************
    // transmit capture
    // ****************************************
    // mac updates after our rising edge, so at the next rising event the
    // synchronised copy already holds the settled nibble
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_data  <= '0;
        end else begin
            tx_valid <= rise_evt && tx_sync.en;
            if (rise_evt && tx_sync.en) begin
                tx_data <= '{err: tx_sync.er, nibble: tx_sync.txd};
            end
        end
    end

endmodule : mii_phy_port_strap_latch

// ### shared/mii_strap_pkg.sv
// shared constants and carrier types for the mii port with strap latch
package mii_strap_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int NIBBLE_W   = 4;
    localparam int ADDR_W     = 5;
    localparam int MODE_W     = 2;
    localparam int FIFO_DEPTH = 4;

    // ****************************************
    // strap layout
    // ****************************************
    // upper station address bits are fixed, only 0..7 can be strapped
    localparam logic [1:0] ADDR_HI_FIXED = 2'h0;
    localparam int RXD_ADDR0_POS = 3;   // rxd[3] -> address bit 0
    localparam int RXD_ADDR1_POS = 2;   // rxd[2] -> address bit 1
    localparam int RXD_ADDR2_POS = 1;   // rxd[1] -> address bit 2
    localparam int RXD_DUPLEX_POS = 0;  // rxd[0] -> duplex strap

    // ****************************************
    // link clock timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int LINK_HALF_NS   = 60;
    // longest half period, rounded down, never below one cycle
    localparam int LINK_HALF_CYC  = (LINK_HALF_NS / CLK_PERIOD_NS) < 1 ?
                                    1 : (LINK_HALF_NS / CLK_PERIOD_NS);
    localparam int DIV_W          = 8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic                err;
        logic [NIBBLE_W-1:0] nibble;
    } nibble_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] station_address;
        logic              duplex;
        logic [MODE_W-1:0] mode_select;
    } strap_set_t;

    typedef struct packed {
        logic [NIBBLE_W-1:0] rxd;
        logic                rx_clk;
        logic                crs;
    } strap_pins_t;

    typedef struct packed {
        logic                en;
        logic                er;
        logic [NIBBLE_W-1:0] txd;
    } tx_pins_t;

endpackage : mii_strap_pkg

// ### logic/nibble_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module nibble_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // ****************************************
    // flags and read port
    // ****************************************
    assign out_valid  = (count != '0);
    // fill level after this edge, so ready can come from a flop
    assign next_count = (push && !pop) ? CW'(count + 1'b1) :
                        (pop && !push) ? CW'(count - 1'b1) : count;
    assign out_data  = mem[rd_ptr];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    // storage, no reset needed on the data itself
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) wr_ptr <= bump(wr_ptr);
            if (pop)  rd_ptr <= bump(rd_ptr);
            count    <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
        end
    end

endmodule : nibble_fifo

// ### dv/mii_strap_chk.sv
// concurrent checks on the ports of the mii port with strap latch
`timescale 1ns/1ps
module mii_strap_chk
    import mii_strap_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 srst,
    input wire logic [mii_strap_pkg::NIBBLE_W-1:0] rxd_in,
    input wire logic [mii_strap_pkg::NIBBLE_W-1:0] rxd_out,
    input wire logic                 rxd_oe,
    input wire logic                 rx_clk_in,
    input wire logic                 rx_clk_out,
    input wire logic                 rx_clk_oe,
    input wire logic                 crs_in,
    input wire logic                 crs_out,
    input wire logic                 crs_oe,
    input wire logic                 rx_dv,
    input wire logic                 rx_er,
    input wire logic                 tx_clk,
    input wire logic                 tx_valid,
    input wire mii_strap_pkg::nibble_word_t tx_data,
    input wire mii_strap_pkg::strap_set_t   straps,
    input wire logic                 straps_valid
);
    import mii_strap_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ****************************************
    // strap latch
    // ****************************************
    // pins are still undriven at the release edge, so one past is enough
    sequence pins_on_s;
        rxd_oe && rx_clk_oe && crs_oe;
    endsequence
    straps_take_a: assert property (
        $rose(straps_valid) |-> straps == {ADDR_HI_FIXED, $past(rxd_in[1]),
        $past(rxd_in[2]), $past(rxd_in[3]), $past(rxd_in[0]),
        $past(crs_in), $past(rx_clk_in)})
        else $error("straps differ from pin levels");
    addr_high_a: assert property (
        straps_valid |-> straps.station_address[4:3] == ADDR_HI_FIXED)
        else $error("upper address bits not zero");
    straps_kept_a: assert property (
        straps_valid && $past(straps_valid) |-> $stable(straps))
        else $error("straps changed after release");
    pins_late_a: assert property (
        $rose(straps_valid) |-> !rxd_oe ##1 pins_on_s)
        else $error("pin drive order wrong");

    // ****************************************
    // link timing
    // ****************************************
    rx_data_edge_a: assert property (
        $changed(rxd_out) |-> $fell(rx_clk_out))
        else $error("receive nibble moved off the falling edge");
    rx_flags_edge_a: assert property (
        $changed(rx_dv) || $changed(rx_er) || $changed(crs_out)
        |-> $fell(rx_clk_out))
        else $error("receive flags moved off the falling edge");
    tx_clk_phase_a: assert property (
        tx_clk == rx_clk_out)
        else $error("link clocks out of phase");
    tx_pulse_a: assert property (
        tx_valid |-> $rose(tx_clk) ##1 !tx_valid)
        else $error("transmit pulse badly placed");
    tx_hold_a: assert property (
        !tx_valid |-> $stable(tx_data))
        else $error("transmit data moved without a pulse");
endmodule : mii_strap_chk

// ### dv/mac_model.sv
// behavioural mac on the far side of the mii
`timescale 1ns/1ps
module mac_model
    import mii_strap_pkg::*;
(
    input  wire logic                tx_clk,
    input  wire logic                rx_clk,
    input  wire logic                rx_dv,
    input  wire logic                rx_er,
    input  wire logic [mii_strap_pkg::NIBBLE_W-1:0] rxd,
    output logic                     tx_en,
    output logic                     tx_er,
    output logic [mii_strap_pkg::NIBBLE_W-1:0] txd
);
    import mii_strap_pkg::*;
    nibble_word_t txq[$];
    nibble_word_t rxq[$];

    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd = 4'h5;
    end

    // launch just after our clock rises; idle data wanders, never parks
    always @(posedge tx_clk) begin
        if (txq.size() > 0) begin
            tx_en <= 1'b1;
            {tx_er, txd} <= txq.pop_front();
        end else begin
            tx_en <= 1'b0;
            tx_er <= 1'b0;
            txd <= ~txd;
        end
    end

    // take a nibble at each rising edge that carries valid
    always @(posedge rx_clk) begin
        if (rx_dv === 1'b1)
            rxq.push_back({rx_er, rxd});
    end
endmodule : mac_model

// ### dv/test_mii_phy_port_strap_latch.sv
// testbench for the mii port with strap latch
`timescale 1ns/1ps
module test_mii_phy_port_strap_latch;
    import mii_strap_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic rx_in_valid = 1'b0;
    logic rx_carrier = 1'b0;
    nibble_word_t rx_in_data = 5'h00;
    logic [3:0] rxd_pull = 4'h0;
    logic clk_pull = 1'b0;
    logic crs_pull = 1'b0;
    logic [3:0] rxd_in, rxd_out, txd;
    logic rxd_oe, rx_clk_in, rx_clk_out, rx_clk_oe, crs_in, crs_out;
    logic crs_oe, rx_dv, rx_er, tx_clk, tx_en, tx_er, tx_valid;
    logic straps_valid, rx_in_ready, full, go;
    nibble_word_t tx_data;
    strap_set_t straps;
    nibble_word_t txs[$];
    logic [7:0] exp;
    int failures = 0;
    int comparisons = 0;

    // short link period keeps the run brief
    mii_phy_port_strap_latch #(.HALF_CYC(3)) dut (
        .clk_sys(clk_sys), .srst(srst), .rx_in_valid(rx_in_valid),
        .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
        .rx_carrier(rx_carrier), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .rx_clk_in(rx_clk_in), .rx_clk_out(rx_clk_out),
        .rx_clk_oe(rx_clk_oe), .crs_in(crs_in), .crs_out(crs_out),
        .crs_oe(crs_oe), .rx_dv(rx_dv), .rx_er(rx_er), .tx_clk(tx_clk),
        .tx_en(tx_en), .txd(txd), .tx_er(tx_er), .tx_valid(tx_valid),
        .tx_data(tx_data), .straps(straps), .straps_valid(straps_valid));
    mac_model mac (.tx_clk(tx_clk), .rx_clk(rx_clk_out), .rx_dv(rx_dv),
        .rx_er(rx_er), .rxd(rxd_out), .tx_en(tx_en), .tx_er(tx_er),
        .txd(txd));

    // shared pins fall back to their pulls whenever nobody drives them
    assign rxd_in = rxd_oe === 1'b1 ? rxd_out : rxd_pull;
    assign rx_clk_in = rx_clk_oe === 1'b1 ? rx_clk_out : clk_pull;
    assign crs_in = crs_oe === 1'b1 ? crs_out : crs_pull;

    always #5 clk_sys = ~clk_sys;

    // tx_valid stands one cycle, so every falling edge looks
    always @(negedge clk_sys) begin
        if (tx_valid === 1'b1)
            txs.push_back(tx_data);
    end

    function automatic nibble_word_t word(int i);
        return {i == 2, 4'(i * 5 + 3)};
    endfunction : word

    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // ****************************************
    // main sequence
    // ****************************************
    // second pass resets in mid-run with the opposite strap levels
    initial begin
        for (int p = 0; p < 2; p++) begin
            srst = 1'b1;
            {rxd_pull, clk_pull, crs_pull} = p ? 6'h1A : 6'h25;
            repeat (16) @(negedge clk_sys);
            chk("oe in reset", {rxd_oe, rx_clk_oe, crs_oe}, 8'h00);
            chk("valid in reset", straps_valid, 8'h00);
            srst = 1'b0;
            repeat (4) @(negedge clk_sys);
            chk("oe after", {rxd_oe, rx_clk_oe, crs_oe}, 8'h07);
            chk("straps valid", straps_valid, 8'h01);
            exp = {2'h0, rxd_pull[1], rxd_pull[2], rxd_pull[3], rxd_pull[0],
                   crs_pull, clk_pull};
            chk("straps", straps, exp);
            // offer six words back to back so the fifo must refuse
            rx_carrier = 1'b1;
            mac.rxq.delete();
            full = 1'b0;
            rx_in_valid = 1'b1;
            for (int i = 0; i < 6; i++) begin
                rx_in_data = word(i);
                do begin
                    go = rx_in_ready;
                    full |= !go;
                    @(negedge clk_sys);
                end while (!go);
            end
            rx_in_valid = 1'b0;
            chk("fifo refused", full, 8'h01);
            for (int k = 0; k < 300 && mac.rxq.size() < 6; k++)
                @(negedge clk_sys);
            chk("rx count", 8'(mac.rxq.size()), 8'h06);
            for (int i = 0; i < 6; i++)
                chk("rx nibble", mac.rxq[i], word(i));
            repeat (12) @(negedge clk_sys);
            chk("carrier on", crs_out, 8'h01);
            rx_carrier = 1'b0;
            repeat (12) @(negedge clk_sys);
            chk("carrier off", crs_out, 8'h00);
            // transmit five nibbles back to back, one with error set
            txs.delete();
            for (int i = 0; i < 5; i++)
                mac.txq.push_back(word(i));
            for (int k = 0; k < 300 && txs.size() < 5; k++)
                @(negedge clk_sys);
            chk("tx count", 8'(txs.size()), 8'h05);
            for (int i = 0; i < 5; i++)
                chk("tx nibble", txs[i], word(i));
            chk("straps kept", straps, exp);
        end
        results();
    end

    // cut a hang short well past the expected run
    initial begin
        #50000;
        failures++;
        results();
    end
endmodule : test_mii_phy_port_strap_latch

bind mii_phy_port_strap_latch mii_strap_chk chk (
    .clk_sys(clk_sys), .srst(srst), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .rx_clk_in(rx_clk_in), .rx_clk_out(rx_clk_out),
    .rx_clk_oe(rx_clk_oe), .crs_in(crs_in), .crs_out(crs_out),
    .crs_oe(crs_oe), .rx_dv(rx_dv), .rx_er(rx_er), .tx_clk(tx_clk),
    .tx_valid(tx_valid), .tx_data(tx_data), .straps(straps),
    .straps_valid(straps_valid));
